// *** common/sleep_id_params.svh ***
`ifndef SLEEP_ID_PARAMS_SVH
`define SLEEP_ID_PARAMS_SVH
`define CMD_SLEEP        8'hb9
`define CMD_IDENTITY     8'h9f
`define CMD_SERIAL       8'hc3
`define CONT_BYTES       4'h6
`define MAKER_IDX        4'h6
`define PROD0_IDX        4'h7
`define PROD1_IDX        4'h8
`define SN_BYTES         4'h8
`define CRC_INIT         8'h00
`define CRC_POLY         8'h07
`define CUSTOMER_NONE    16'h0000
`define CLK_MHZ          40
`define WAKE_REC_TIME_US 400
`define WAKE_REC_CYCLES  (`WAKE_REC_TIME_US * `CLK_MHZ)
`define WAKE_CNT_W       14
`define SYNC_LATENCY     4
`endif

// *** common/sleep_id_pkg.sv ***
package sleep_id_pkg;
    // pins from the host, select active low
    typedef struct packed {
        logic selN;
        logic sck;
        logic din;
    } pinIn_t;
    // serial data out with its enable
    typedef struct packed {
        logic q;
        logic qOe;
    } pinOut_t;
    typedef enum logic [2:0] {
        ST_CMD,
        ST_SHIFT,
        ST_IGNORE,
        ST_ARMED,
        ST_SLEEP,
        ST_WAKE
    } state_t;
    typedef enum logic {
        STREAM_ID,
        STREAM_SN
    } stream_t;
endpackage

// *** hdl/sleep_id_serial_commands.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sleep_id_params.svh"
module sleep_id_serial_commands #(
    parameter int unsigned RecCycles  = `WAKE_REC_CYCLES,
    parameter logic [7:0]  ContCode   = 8'h5a,            // arbitrary value
    parameter logic [7:0]  MakerCode  = 8'h3c,            // arbitrary value
    parameter logic [2:0]  Family     = 3'h2,             // arbitrary value
    parameter logic [4:0]  Density    = 5'h04,            // arbitrary value
    parameter logic [1:0]  SubType    = 2'h1,             // arbitrary value
    parameter logic [2:0]  Revision   = 3'h2,             // arbitrary value
    parameter logic        HasSerial  = 1'b1,
    parameter logic [15:0] CustomerId = `CUSTOMER_NONE,
    parameter logic [39:0] UniqueNum  = 40'h12_3456_789a  // arbitrary value
) (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire sleep_id_pkg::pinIn_t   pins,
    output var  sleep_id_pkg::pinOut_t  pinOut,
    output var  logic                   asleep,
    output var  logic                   waking
);
    // bitwise crc, same result as the byte table with init 0
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = `CRC_INIT;
        for (int i = 55; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    sleep_id_pkg::pinIn_t  s1_q, s2_q, s3_q;
    sleep_id_pkg::state_t  state_q, state_d;
    sleep_id_pkg::stream_t kind_q;
    logic [7:0]            shiftIn_q;
    logic [3:0]            inCnt_q;
    logic [6:0]            outCnt_q;
    logic                  miso_q;
    logic                  oe_q;
    logic [`WAKE_CNT_W-1:0] wakeCnt_q;

    // two-stage synchroniser plus one stage for edge finding
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '{selN: 1'b1, sck: 1'b0, din: 1'b0};
            s2_q <= '{selN: 1'b1, sck: 1'b0, din: 1'b0};
            s3_q <= '{selN: 1'b1, sck: 1'b0, din: 1'b0};
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // edge decode on the synchronised pins
    wire        selRise = s2_q.selN & ~s3_q.selN;
    wire        selFall = ~s2_q.selN & s3_q.selN;
    wire        selAct  = ~s2_q.selN & ~s3_q.selN;
    wire        sckRise = selAct & s2_q.sck & ~s3_q.sck;
    wire        sckFall = selAct & ~s2_q.sck & s3_q.sck;
    wire [7:0]  cmdByte = {shiftIn_q[6:0], s2_q.din};
    wire        cmdDone = (state_q == sleep_id_pkg::ST_CMD) && sckRise && (inCnt_q == 4'h7);
    wire        isSleep = cmdByte == `CMD_SLEEP;
    wire        isIdent = cmdByte == `CMD_IDENTITY;
    wire        isSer   = (cmdByte == `CMD_SERIAL) && HasSerial;
    wire        wakeDone = wakeCnt_q >= `WAKE_CNT_W'(RecCycles - `SYNC_LATENCY);
    wire        inShift = state_q == sleep_id_pkg::ST_SHIFT;

    // stream contents
    wire [3:0]  byteIdx = outCnt_q[6:3];
    wire [7:0]  crcByte = crc8({CustomerId, UniqueNum});
    wire [63:0] snWord  = {CustomerId, UniqueNum, crcByte};
    wire [7:0]  prod0   = {Family, Density};
    wire [7:0]  prod1   = {SubType, Revision, 3'h0};
    wire [7:0]  idByte  = (byteIdx < `CONT_BYTES)   ? ContCode  :
                          (byteIdx == `MAKER_IDX)   ? MakerCode :
                          (byteIdx == `PROD0_IDX)   ? prod0     :
                          (byteIdx == `PROD1_IDX)   ? prod1     : 8'h00;
    wire [7:0]  snByte  = (byteIdx < `SN_BYTES) ?
                          snWord[6'(63 - 8 * byteIdx) -: 8] : 8'h00;
    wire [7:0]  curByte = (kind_q == sleep_id_pkg::STREAM_ID) ? idByte : snByte;
    wire        nextBit = curByte[~outCnt_q[2:0]];

    // command, sleep and wake sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            sleep_id_pkg::ST_CMD: begin
                if (cmdDone) begin
                    if (isSleep) begin
                        state_d = sleep_id_pkg::ST_ARMED;
                    end else if (isIdent || isSer) begin
                        state_d = sleep_id_pkg::ST_SHIFT;
                    end else begin
                        state_d = sleep_id_pkg::ST_IGNORE;
                    end
                end
            end
            sleep_id_pkg::ST_SHIFT, sleep_id_pkg::ST_IGNORE: begin
                if (selRise) begin
                    state_d = sleep_id_pkg::ST_CMD;
                end
            end
            sleep_id_pkg::ST_ARMED: begin
                if (selRise) begin
                    state_d = sleep_id_pkg::ST_SLEEP;
                end
            end
            sleep_id_pkg::ST_SLEEP: begin
                if (selFall) begin
                    state_d = sleep_id_pkg::ST_WAKE;
                end
            end
            sleep_id_pkg::ST_WAKE: begin
                if (wakeDone) begin
                    state_d = s2_q.selN ? sleep_id_pkg::ST_CMD : sleep_id_pkg::ST_IGNORE;
                end
            end
            default: state_d = sleep_id_pkg::ST_CMD;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= sleep_id_pkg::ST_CMD;
        end else begin
            state_q <= state_d;
        end
    end

    // command byte capture, sleep ignores clock and data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inCnt_q   <= 4'h0;
            shiftIn_q <= 8'h00;
        end else if (selFall || selRise) begin
            inCnt_q   <= 4'h0;
        end else if (state_q == sleep_id_pkg::ST_CMD && sckRise) begin
            inCnt_q   <= inCnt_q + 4'h1;
            shiftIn_q <= cmdByte;
        end
    end

    // stream kind chosen with the command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            kind_q <= sleep_id_pkg::STREAM_ID;
        end else if (cmdDone) begin
            kind_q <= isIdent ? sleep_id_pkg::STREAM_ID : sleep_id_pkg::STREAM_SN;
        end
    end

    // output shifter: one bit per falling clock edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            outCnt_q <= 7'h00;
            miso_q   <= 1'b0;
        end else if (!inShift) begin
            outCnt_q <= 7'h00;
        end else if (sckFall) begin
            miso_q   <= nextBit;
            outCnt_q <= (outCnt_q == 7'h7f) ? outCnt_q : outCnt_q + 7'h01;
        end
    end

    // output enable, dropped at deselect and outside reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oe_q <= 1'b0;
        end else if (selRise || !inShift) begin
            oe_q <= 1'b0;
        end else if (sckFall) begin
            oe_q <= 1'b1;
        end
    end

    // wake recovery counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeCnt_q <= '0;
        end else if (state_q == sleep_id_pkg::ST_WAKE) begin
            wakeCnt_q <= wakeCnt_q + `WAKE_CNT_W'(1);
        end else begin
            wakeCnt_q <= '0;
        end
    end

    assign pinOut     = '{q: miso_q, qOe: oe_q};
    assign asleep     = state_q == sleep_id_pkg::ST_SLEEP;
    assign waking     = state_q == sleep_id_pkg::ST_WAKE;

    // checks
    sequence sleepArmed;
        state_q == sleep_id_pkg::ST_ARMED && selRise;
    endsequence
    sequence wakeStart;
        state_q == sleep_id_pkg::ST_SLEEP && selFall;
    endsequence
    sequence idCmd;
        cmdDone && isIdent;
    endsequence
    sequence snCmd;
        cmdDone && isSer;
    endsequence

    sleep_entry_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sleepArmed |=> (state_q == sleep_id_pkg::ST_SLEEP) [*2])
        else $error("sleep not entered after select rise");

    sleep_quiet_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_q == sleep_id_pkg::ST_SLEEP && $past(state_q) == sleep_id_pkg::ST_SLEEP
        |-> !oe_q && $stable(inCnt_q) && $stable(shiftIn_q))
        else $error("activity while asleep");

    wake_start_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        wakeStart |=> waking && wakeCnt_q == '0)
        else $error("wake did not start on select fall");

    wake_bound_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        waking |-> wakeCnt_q < `WAKE_CNT_W'(RecCycles))
        else $error("wake recovery too long");

    wake_quiet_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        waking |-> !oe_q)
        else $error("output driven during wake");

    id_stream_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        idCmd |=> inShift && kind_q == sleep_id_pkg::STREAM_ID && outCnt_q == 7'h00)
        else $error("identity stream not started");

    cont_bytes_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        inShift && kind_q == sleep_id_pkg::STREAM_ID && byteIdx < `CONT_BYTES
        |-> curByte == ContCode)
        else $error("continuation byte wrong");

    product_id_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        inShift && kind_q == sleep_id_pkg::STREAM_ID && byteIdx == `PROD1_IDX
        |-> curByte[2:0] == 3'h0 && curByte[7:6] == SubType)
        else $error("product byte layout wrong");

    sn_stream_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        snCmd |=> inShift && kind_q == sleep_id_pkg::STREAM_SN)
        else $error("serial stream not started");

    sn_layout_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        inShift && kind_q == sleep_id_pkg::STREAM_SN && byteIdx == 4'h1
        |-> curByte == CustomerId[7:0])
        else $error("serial byte order wrong");

    customer_zero_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        inShift && kind_q == sleep_id_pkg::STREAM_SN && byteIdx == 4'h0
        && CustomerId == `CUSTOMER_NONE |-> curByte == 8'h00)
        else $error("customer field not zero");

    crc_byte_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sckFall && inShift && kind_q == sleep_id_pkg::STREAM_SN && outCnt_q == 7'h38
        |=> miso_q == crcByte[7])
        else $error("crc byte not sent last");

    deselect_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        selRise |=> !oe_q && !inShift)
        else $error("read not ended by select rise");

    msb_first_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sckFall && inShift && outCnt_q[2:0] == 3'h0 |=> oe_q && miso_q == $past(curByte[7]))
        else $error("byte not sent msb first");
endmodule
`default_nettype wire

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic                  clk,
    input  wire sleep_id_pkg::pinOut_t pinOut,
    output var  sleep_id_pkg::pinIn_t  pins
);
    // idle bus: deselected, clock low for mode 0
    initial pins = '{selN: 1'b1, sck: 1'b0, din: 1'b0};

    // crc-8 with poly 07 from zero, bitwise form of the lookup table
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int b = 6; b >= 0; b--) begin
            c = c ^ d[b*8 +: 8];
            for (int k = 0; k < 8; k++) begin
                c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
            end
        end
        return c;
    endfunction

    // one mode 0 frame: command, then nbits read back, four clk per sck phase
    task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] rx [10],
                        output logic oeAll, output logic oeAny, output logic oeEnd);
        oeAll = 1'b1;
        oeAny = 1'b0;
        rx = '{default: 8'h00};
        @(posedge clk);
        pins.selN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8 + nbits; i++) begin
            @(posedge clk);
            pins.sck <= 1'b0;
            // command msb first, then a changing pattern while reading
            pins.din <= (i < 8) ? cmd[7 - i] : ~pins.din;
            repeat (4) @(posedge clk);
            pins.sck <= 1'b1;
            @(negedge clk);
            if (i >= 8) begin
                // a released line floats: show the inverse of the last level
                rx[(i - 8) / 8] = {rx[(i - 8) / 8][6:0],
                                   pinOut.qOe ? pinOut.q : ~pinOut.q};
                oeAll = oeAll & pinOut.qOe;
                oeAny = oeAny | pinOut.qOe;
            end
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        pins.sck <= 1'b0;
        @(posedge clk);
        pins.selN <= 1'b1;
        pins.din  <= ~pins.din;
        repeat (5) @(posedge clk);
        @(negedge clk);
        oeEnd = pinOut.qOe;
    endtask
endmodule
`default_nettype wire

// *** tb/sleep_id_serial_commands_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sleep_id_serial_commands_tb_top;
    localparam int unsigned RecCycles  = 400;
    localparam logic [7:0]  ContCode   = 8'h5a;           // arbitrary value
    localparam logic [7:0]  MakerCode  = 8'h3c;           // arbitrary value
    localparam logic [7:0]  Prod0      = {3'h2, 5'h04};   // arbitrary value
    localparam logic [7:0]  Prod1      = {2'h1, 3'h2, 3'h0}; // arbitrary value
    localparam logic [39:0] UniqueNum  = 40'h12_3456_789a; // arbitrary value

    logic                  clk = 1'b0;
    logic                  arstN = 1'b0;
    sleep_id_pkg::pinIn_t  pins;
    sleep_id_pkg::pinOut_t pinOut;
    logic                  asleep;
    logic                  waking;
    int                    errorCnt = 0;
    int                    checks = 0;
    logic [7:0]            rx [10];
    logic                  oeAll;
    logic                  oeAny;
    logic                  oeEnd;

    always #12.5 clk = ~clk;

    sleep_id_serial_commands #(.RecCycles(RecCycles), .ContCode(ContCode),
        .MakerCode(MakerCode), .Family(Prod0[7:5]), .Density(Prod0[4:0]),
        .SubType(Prod1[7:6]), .Revision(Prod1[5:3]), .HasSerial(1'b1),
        .CustomerId(16'h0000), .UniqueNum(UniqueNum)) i_dut (
        .clk(clk), .arst_n(arstN), .pins(pins), .pinOut(pinOut),
        .asleep(asleep), .waking(waking));

    spi_host_model i_host (.clk(clk), .pinOut(pinOut), .pins(pins));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_identity();
        logic [7:0] exp [10];
        exp = '{ContCode, ContCode, ContCode, ContCode, ContCode, ContCode,
                MakerCode, Prod0, Prod1, 8'h00};
        i_host.xfer(8'h9f, 80, rx, oeAll, oeAny, oeEnd);
        for (int k = 0; k < 10; k++) check("identity byte", exp[k], rx[k]);
        check("qOe while reading", 8'h01, {7'h00, oeAll});
        check("qOe after deselect", 8'h00, {7'h00, oeEnd});
        $display("test identity done");
    endtask

    task automatic test_serial();
        logic [63:0] sn;
        sn = {16'h0000, UniqueNum, i_host.crc8({16'h0000, UniqueNum})};
        i_host.xfer(8'hc3, 72, rx, oeAll, oeAny, oeEnd);
        for (int k = 0; k < 8; k++) check("serial byte", sn[63 - 8 * k -: 8], rx[k]);
        check("serial tail", 8'h00, rx[8]);
        check("host crc", i_host.crc8({rx[0], rx[1], rx[2], rx[3], rx[4], rx[5], rx[6]}), rx[7]);
        check("qOe after deselect", 8'h00, {7'h00, oeEnd});
        $display("test serial done");
    endtask

    // unknown command stays quiet; read cut off late, a fresh read restarts
    task automatic test_abort();
        i_host.xfer(8'h5e, 16, rx, oeAll, oeAny, oeEnd);
        check("qOe on unknown command", 8'h00, {7'h00, oeAny});
        i_host.xfer(8'h9f, 60, rx, oeAll, oeAny, oeEnd);
        check("qOe after abort", 8'h00, {7'h00, oeEnd});
        i_host.xfer(8'h9f, 8, rx, oeAll, oeAny, oeEnd);
        check("restarted first byte", ContCode, rx[0]);
        $display("test abort done");
    endtask

    task automatic test_sleep();
        int n;
        i_host.xfer(8'hb9, 0, rx, oeAll, oeAny, oeEnd);
        check("asleep after entry", 8'h01, {7'h00, asleep});
        check("qOe asleep", 8'h00, {7'h00, pinOut.qOe});
        // dummy read wakes the device and is refused
        i_host.xfer(8'h9f, 16, rx, oeAll, oeAny, oeEnd);
        check("qOe during wake", 8'h00, {7'h00, oeAny});
        check("waking", 8'h01, {7'h00, waking});
        n = 0;
        while (waking === 1'b1 && n < RecCycles) begin
            @(negedge clk);
            n++;
        end
        check("wake ends in time", 8'h00, {7'h00, waking});
        check("awake", 8'h00, {7'h00, asleep});
        i_host.xfer(8'h9f, 8, rx, oeAll, oeAny, oeEnd);
        check("read after wake", ContCode, rx[0]);
        $display("test sleep done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        $display("[FAIL] watchdog expected done seen timeout");
        end_sim();
    end

    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        arstN <= 1'b1;
        repeat (4) @(posedge clk);
        test_identity();
        test_serial();
        test_abort();
        test_sleep();
        end_sim();
    end
endmodule
`default_nettype wire
